/* sbac_pkg.sv */
// package: constants and types for the serial byte-access control registers
package sbac_pkg;
  // ==========================================================
  // target address and command code
  localparam logic [6:0] TARGET_ADDR = 7'h69;
  localparam int CMD_BYTE_MODE_BIT = 7;
  // ==========================================================
  // register indices
  localparam logic [6:0] IDX_DRIVE_FS = 7'h00;
  localparam logic [6:0] IDX_PAIR_EN = 7'h01;
  // ==========================================================
  // field positions
  localparam int DRIVE_BIT = 6;
  localparam int PAIR_DEBUG_BIT = 2;
  localparam int PAIR_ONE_BIT = 1;
  localparam int PAIR_ZERO_BIT = 0;
  // ==========================================================
  // reset values, fixed masks, unmapped read value and bit counts
  localparam logic [7:0] DRIVE_FS_RESET = 8'h40;
  localparam logic [7:0] DRIVE_FS_WMASK = 8'h40;
  localparam logic [7:0] PAIR_EN_RESET = 8'h7f;
  localparam logic [7:0] PAIR_EN_WMASK = 8'h07;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // count after the ack clock has risen, so its fall closes the byte
  localparam logic [3:0] BIT_ACK_END = 4'h9;
  // ==========================================================
  // transaction phases
  typedef enum logic [2:0] {
    SBAC_IDLE, SBAC_ADDR, SBAC_CMD, SBAC_WDATA, SBAC_RDATA, SBAC_RACK, SBAC_WAIT
  } sbac_phase_t;
  // clock outputs control bundle
  typedef struct packed {
    logic periph_high_drive;
    logic debug_pair_en;
    logic proc1_pair_en;
    logic proc0_pair_en;
  } sbac_clk_ctrl_t;
endpackage

/* sbac_target.sv */
// serial two-wire target giving byte access to the first two control bytes
`timescale 1ns/1ns
// Notes on behaviour
// - write: address, write bit, command, both acknowledged
// - command msb set selects indexed byte access
// - write data byte acknowledged and stored
// - read: repeated start, address read, byte returned
// - byte0 bit6 sets peripheral clock drive strength
// - byte0 bits4..0 show latched frequency selects
// - byte1 bits2..0 enable processor clock pairs
// - answer only own address, others ignored
// - defaults load at reset, bus always usable
module sbac_target
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // serial bus, data is open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_n,
  // power-up strap pins
  input wire logic [4:0] freq_select_pins,
  // clock output controls
  output sbac_pkg::sbac_clk_ctrl_t clk_ctrl,
  output logic [4:0] freq_select_latched
);
  // ==========================================================
  // synchronisers and edge detection
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [4:0] fs_sync0;
  logic [4:0] fs_sync1;
  logic scl_d;
  logic sda_d;
  logic strap_taken;
  logic [1:0] strap_fill;
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      fs_sync0 <= 5'h00;
      fs_sync1 <= 5'h00;
    end
    else
    begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
      fs_sync0 <= freq_select_pins;
      fs_sync1 <= fs_sync0;
    end
  end
  wire scl = scl_sync[1];
  wire sda = sda_sync[1];
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_seen = scl & scl_d & sda_d & ~sda;
  wire stop_seen = scl & scl_d & ~sda_d & sda;
  // ==========================================================
  // control bytes
  logic [7:0] drive_and_freq_select_status;
  logic [7:0] processor_clock_pair_enables;
  // straps caught once after reset release, after two flops
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strap_fill <= 2'h0;
      strap_taken <= 1'b0;
      freq_select_latched <= 5'h00;
    end
    else
    begin
      // wait until both strap flops hold pin values, not reset zeros
      strap_fill <= {strap_fill[0], 1'b1};
      if (strap_fill[1] && !strap_taken)
      begin
        strap_taken <= 1'b1;
        freq_select_latched <= fs_sync1;
      end
    end
  end
  // ==========================================================
  // protocol engine
  sbac_pkg::sbac_phase_t phase;
  sbac_pkg::sbac_phase_t next_phase;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [6:0] index;
  logic byte_mode;
  logic drive_ack;
  wire byte_done = scl_rise && (bit_cnt == sbac_pkg::BIT_LAST);
  wire [7:0] shifted = {shift[6:0], sda};
  wire addr_match = shifted[7:1] == sbac_pkg::TARGET_ADDR;
  wire is_read = shifted[0];
  wire cmd_byte = shifted[sbac_pkg::CMD_BYTE_MODE_BIT];
  wire hit_fs = index == sbac_pkg::IDX_DRIVE_FS;
  wire hit_pair = index == sbac_pkg::IDX_PAIR_EN;
  // reserved bits come from the reset constants, writes only touch the mask
  wire [7:0] fs_view = (drive_and_freq_select_status & sbac_pkg::DRIVE_FS_WMASK)
    | {3'h0, freq_select_latched};
  wire [7:0] read_byte = hit_fs ? fs_view :
    hit_pair ? processor_clock_pair_enables : sbac_pkg::UNMAPPED_READ;
  wire write_ok = (phase == sbac_pkg::SBAC_WDATA) && byte_done && byte_mode;
  // ack only a matching address byte and a write's command and data bytes, so a foreign or extra byte stays unanswered
  wire ack_wanted = (phase == sbac_pkg::SBAC_ADDR) ? addr_match :
    (phase == sbac_pkg::SBAC_CMD) || (phase == sbac_pkg::SBAC_WDATA);
  always_comb
  begin
    next_phase = phase;
    unique case (phase)
      sbac_pkg::SBAC_IDLE: next_phase = phase;
      sbac_pkg::SBAC_ADDR:
        if (byte_done)
          next_phase = !addr_match ? sbac_pkg::SBAC_IDLE :
            is_read ? sbac_pkg::SBAC_RDATA : sbac_pkg::SBAC_CMD;
      sbac_pkg::SBAC_CMD:
        if (byte_done)
          next_phase = sbac_pkg::SBAC_WDATA;
      sbac_pkg::SBAC_WDATA:
        if (byte_done)
          next_phase = sbac_pkg::SBAC_WAIT;
      sbac_pkg::SBAC_RDATA:
        if (byte_done)
          next_phase = sbac_pkg::SBAC_RACK;
      sbac_pkg::SBAC_RACK:
        if (scl_fall && bit_cnt == sbac_pkg::BIT_ACK_END)
          next_phase = sbac_pkg::SBAC_WAIT;
      sbac_pkg::SBAC_WAIT: next_phase = phase;
    endcase
  end
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase <= sbac_pkg::SBAC_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      index <= 7'h00;
      byte_mode <= 1'b0;
      drive_ack <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else if (start_seen)
    begin
      // a repeated start keeps the index for the read that follows
      phase <= sbac_pkg::SBAC_ADDR;
      bit_cnt <= 4'h0;
      drive_ack <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else if (stop_seen)
    begin
      phase <= sbac_pkg::SBAC_IDLE;
      drive_ack <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      phase <= next_phase;
      if (scl_rise && bit_cnt < sbac_pkg::BIT_ACK)
        shift <= shifted;
      // the ack clock is counted too, else its rise would pass for a data bit
      if (scl_rise && bit_cnt <= sbac_pkg::BIT_ACK)
        bit_cnt <= bit_cnt + 4'h1;
      if (phase == sbac_pkg::SBAC_CMD && byte_done)
      begin
        byte_mode <= cmd_byte;
        index <= shifted[6:0];
      end
      if (byte_done)
        drive_ack <= ack_wanted;
      if (scl_fall)
      begin
        if (bit_cnt == sbac_pkg::BIT_ACK_END)
        begin
          // ack bit over, start next byte
          bit_cnt <= 4'h0;
          drive_ack <= 1'b0;
          if (phase == sbac_pkg::SBAC_RDATA)
          begin
            shift <= read_byte;
            sda_oe_n <= ~read_byte[7] ? 1'b0 : 1'b1;
          end
          else
            sda_oe_n <= 1'b1;
        end
        else if (drive_ack)
          sda_oe_n <= 1'b0;
        else if (phase == sbac_pkg::SBAC_RDATA && bit_cnt != 4'h0)
          sda_oe_n <= shift[7];
        else if (phase == sbac_pkg::SBAC_RACK)
          sda_oe_n <= 1'b1;
      end
    end
  end
  // ==========================================================
  // register storage, reserved bits fixed
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      drive_and_freq_select_status <= sbac_pkg::DRIVE_FS_RESET;
      processor_clock_pair_enables <= sbac_pkg::PAIR_EN_RESET;
    end
    else if (write_ok && !start_seen && !stop_seen)
    begin
      if (hit_fs)
        drive_and_freq_select_status <= (shifted & sbac_pkg::DRIVE_FS_WMASK)
          | (sbac_pkg::DRIVE_FS_RESET & ~sbac_pkg::DRIVE_FS_WMASK);
      if (hit_pair)
        processor_clock_pair_enables <= (shifted & sbac_pkg::PAIR_EN_WMASK)
          | (sbac_pkg::PAIR_EN_RESET & ~sbac_pkg::PAIR_EN_WMASK);
    end
  end
  // ==========================================================
  // registered control outputs
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      clk_ctrl <= '1;
    else
    begin
      clk_ctrl.periph_high_drive <= drive_and_freq_select_status[sbac_pkg::DRIVE_BIT];
      clk_ctrl.debug_pair_en <= processor_clock_pair_enables[sbac_pkg::PAIR_DEBUG_BIT];
      clk_ctrl.proc1_pair_en <= processor_clock_pair_enables[sbac_pkg::PAIR_ONE_BIT];
      clk_ctrl.proc0_pair_en <= processor_clock_pair_enables[sbac_pkg::PAIR_ZERO_BIT];
    end
  end
endmodule

/* sbac_props.sv */
// checker: port-level properties of the byte-access target
`timescale 1ns/1ns
module sbac_props
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // bus and straps
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe_n,
  input wire logic [4:0] freq_select_pins,
  // controls
  input wire sbac_pkg::sbac_clk_ctrl_t clk_ctrl,
  input wire logic [4:0] freq_select_latched
);
  // ==========
  // cycles since reset, saturating
  logic [2:0] up_cnt;
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n) up_cnt <= 3'h0;
    else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_ack_held;
    !sda_oe_n [*4];
  endsequence
  AST_RST_VAL: assert property ($rose(arst_n) |-> clk_ctrl == 4'hf && sda_oe_n)
    else $error("bad reset values");
  AST_STRAP: assert property ($rose(arst_n) |-> ##3 freq_select_latched == freq_select_pins)
    else $error("straps not latched");
  AST_STRAP_HOLD: assert property (up_cnt == 3'h7 |-> $stable(freq_select_latched))
    else $error("latched straps moved");
  AST_SCL_HIGH: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n))
    else $error("data moved while clock high");
  AST_FALL_DLY: assert property ($fell(scl_in) |=> $stable(sda_oe_n))
    else $error("data answered too early");
  AST_PULL_LOW: assert property ($fell(sda_oe_n) |-> !scl_in)
    else $error("pull-low began with clock high");
  AST_ACK_LEN: assert property ($fell(sda_oe_n) |-> s_ack_held)
    else $error("acknowledge too short");
  AST_CTRL_UPD: assert property ($changed(clk_ctrl) |-> scl_in && sda_oe_n)
    else $error("controls changed outside data bit");
endmodule
bind sbac_target sbac_props u_props (.clk_sys(clk_sys), .arst_n(arst_n), .scl_in(scl_in),
  .sda_in(sda_in), .sda_oe_n(sda_oe_n), .freq_select_pins(freq_select_pins),
  .clk_ctrl(clk_ctrl), .freq_select_latched(freq_select_latched));

/* sbac_host.sv */
// host model: drives byte write and read transfers on the two-wire bus
`timescale 1ns/1ns
module sbac_host
(
  // clock
  input wire logic clk_sys,
  // bus: resolved data in, clock and pull-low out
  input wire logic sda,
  output logic scl,
  output logic sda_drv_n
);
  // ==========
  // bit timing, six cycles a phase keeps each level over four
  initial
  begin
    scl = 1'b1;
    sda_drv_n = 1'b1;
  end
  task automatic half();
    repeat (6) @(posedge clk_sys);
    #2;
  endtask
  // start when go is 1, stop otherwise
  task automatic cond(input logic go);
    sda_drv_n = go;
    half();
    scl = 1'b1;
    half();
    sda_drv_n = !go;
    half();
    scl = !go;
    half();
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_drv_n = b;
    half();
    scl = 1'b1;
    half();
    r = sda;
    scl = 1'b0;
    half();
  endtask
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(1'b1, nak);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d,
    output logic [2:0] nk);
    logic [7:0] z;
    cond(1'b1);
    xbyte(a, z, nk[2]);
    xbyte(c, z, nk[1]);
    xbyte(d, z, nk[0]);
    cond(1'b0);
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] q, output logic [2:0] nk);
    logic [7:0] z;
    cond(1'b1);
    xbyte(8'hd2, z, nk[2]);
    xbyte(c, z, nk[1]);
    cond(1'b1);
    xbyte(8'hd3, z, nk[0]);
    xbyte(8'hff, q, z[0]);
    cond(1'b0);
  endtask
endmodule

/* sbac_target_test.sv */
// testbench: byte transfers against the control-byte target
`timescale 1ns/1ns
module sbac_target_test;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic scl;
  logic sda_drv_n;
  logic sda_oe_n;
  logic [4:0] straps = 5'h15;
  logic [4:0] latched;
  sbac_pkg::sbac_clk_ctrl_t clk_ctrl;
  wire sda = sda_drv_n & sda_oe_n;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] q;
  logic [2:0] nk;
  always #10 clk_sys = ~clk_sys;
  sbac_target DUT (.clk_sys(clk_sys), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
    .sda_oe_n(sda_oe_n), .freq_select_pins(straps), .clk_ctrl(clk_ctrl),
    .freq_select_latched(latched));
  sbac_host u_host (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_drv_n(sda_drv_n));
  // ==========
  // checking and closing
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h got %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    if (n_fail == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      end_sim();
    end
  end
  // ==========
  // scenarios
  task automatic t_defaults();
    chk("ctrl", 8'h0f, {4'h0, clk_ctrl});
    chk("latched", {3'h0, straps}, {3'h0, latched});
    u_host.rd(8'h80, q, nk);
    chk("byte0", {3'h2, straps}, q);
    u_host.rd(8'h81, q, nk);
    chk("byte1", 8'h7f, q);
    chk("rd acks", 8'h00, {5'h0, nk});
  endtask
  task automatic t_drive();
    u_host.wr(8'hd2, 8'h80, 8'hbf, nk);
    chk("drive low", 8'h07, {4'h0, clk_ctrl});
    u_host.rd(8'h80, q, nk);
    chk("byte0 low", {3'h0, straps}, q);
    u_host.wr(8'hd2, 8'h80, 8'h40, nk);
    chk("drive high", 8'h0f, {4'h0, clk_ctrl});
  endtask
  task automatic t_refuse();
    u_host.wr(8'hd4, 8'h81, 8'h00, nk);
    chk("wrong addr", 8'h07, {5'h0, nk});
    u_host.wr(8'hd2, 8'h01, 8'h00, nk);
    u_host.wr(8'hd2, 8'h85, 8'h00, nk);
    chk("ctrl kept", 8'h0f, {4'h0, clk_ctrl});
    u_host.rd(8'h85, q, nk);
    chk("unmapped", 8'h00, q);
  endtask
  task automatic t_pairs();
    logic [2:0] m;
    for (int i = 0; i < 3; i++)
    begin
      m = 3'h7 ^ (3'h1 << i);
      u_host.wr(8'hd2, 8'h81, {5'h10, m}, nk);
      chk("wr acks", 8'h00, {5'h0, nk});
      chk("pairs", {5'h01, m}, {4'h0, clk_ctrl});
      u_host.rd(8'h81, q, nk);
      chk("byte1 rd", {5'h0f, m}, q);
    end
  endtask
  initial
  begin
    repeat (10) @(posedge clk_sys);
    #2;
    arst_n = 1'b1;
    repeat (6) @(posedge clk_sys);
    #2;
    t_defaults();
    t_drive();
    t_refuse();
    t_pairs();
    end_sim();
  end
endmodule
